// [bench/pcsm_board.sv]
// Board logic resolving the multiplexed pins
`timescale 1ns/1ps
`default_nettype none
module pcsm_board (
   // Device and board drivers
   input  wire logic [7:0] pin_out_i,
   input  wire logic [7:0] pin_oe_i,
   input  wire logic [7:0] board_drive_i,
   // Level seen on each pin
   output logic      [7:0] pin_level_o
);
   // Board yields a pin whenever the device drives it
   assign pin_level_o = (pin_out_i & pin_oe_i) | (board_drive_i & ~pin_oe_i);
endmodule : pcsm_board
`default_nettype wire

// [bench/pcsm_props.sv]
// Port assertions for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module pcsm_props #(
   parameter logic [3:0] SILICON_VERSION    = 4'h3,
   parameter logic [3:0] SILICON_SUBVERSION = 4'h5
) (
   // Clock, reset and bus
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   // Pins and controls
   input wire logic [7:0]  pin_in_i,
   input wire logic [7:0]  pin_out_o,
   input wire logic [7:0]  pin_oe_o,
   input wire logic        boundary_scan_on_i,
   input wire logic        monitor_output_pin_oe_o,
   input wire logic        fast_pad_switching_o,
   input wire logic        clock_output_run_o
);
   wire       take = hsel_i & hready_i & htrans_i[1];
   wire [7:0] idx  = haddr_i[9:2];
   wire       rd   = take & !hwrite_i;
   wire       wr   = take & hwrite_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   chk_clock_run: assert property (
      clock_output_run_o != pin_oe_o[6]) else $error("clock run bad");
   chk_scan_strap: assert property (
      boundary_scan_on_i |=> pin_oe_o[3:0] == 4'h0) else $error("scan oe");
   // Guard: the input sample taken during reset is not a pin level
   chk_input_read: assert property (
      rd && idx == 8'h46 && $past(resetn_i) |=>
      hrdata_o == {24'h0, $past(pin_in_i, 2)}) else $error("input read");
   chk_rev_read: assert property (
      rd && idx == 8'h7f |=> hrdata_o ==
      {24'h0, SILICON_VERSION, SILICON_SUBVERSION}) else $error("rev read");
   chk_oe_write: assert property (
      wr && idx == 8'h44 |=> ##2 pin_oe_o[7:4] == $past(hwdata_i[7:4], 2))
      else $error("oe write");
   chk_out_write: assert property (
      wr && idx == 8'h45 |=> ##2 pin_out_o == $past(hwdata_i[7:0], 2))
      else $error("out write");
   chk_fast_pad: assert property (
      wr && idx == 8'h47 |=> ##2
      fast_pad_switching_o == $past(hwdata_i[7], 2)) else $error("fast pad");
   chk_mon_float: assert property (
      wr && idx == 8'h47 |=> ##2 monitor_output_pin_oe_o ==
      ($past(hwdata_i[3:0], 2) inside {[4'h2:4'h9]})) else $error("mon oe");
endmodule : pcsm_props
bind pcsm_top pcsm_props #(.SILICON_VERSION(SILICON_VERSION),
   .SILICON_SUBVERSION(SILICON_SUBVERSION)) u_props (.*);
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
   // Arbitrary neutral revision values
   localparam logic [3:0] VER = 4'h3;
   localparam logic [3:0] SUB = 4'h5;
   int                      compares    = 0;
   int                      miscompares = 0;
   logic                    mclk_i      = 1'b0;
   logic                    resetn_i    = 1'b0;
   logic                    hsel        = 1'b0;
   logic                    hwrite      = 1'b0;
   logic                    scan_on     = 1'b0;
   logic [1:0]              htrans      = 2'b00;
   logic [31:0]             haddr       = 32'h0;
   logic [31:0]             hwdata      = 32'h0;
   logic [7:0]              board       = 8'h3C;
   pcsm_pkg::pcsm_monitor_t mon_src     = '0;
   logic [31:0]             hrdata;
   logic [7:0]              pin_in, pin_out, pin_oe;
   logic                    hready, hresp, mon_pin, mon_oe, fast, clk_run;

   always #50 mclk_i = ~mclk_i;

   pcsm_top #(.SILICON_VERSION(VER), .SILICON_SUBVERSION(SUB)) dut (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .pin_in_i(pin_in),
      .pin_out_o(pin_out), .pin_oe_o(pin_oe), .boundary_scan_on_i(scan_on),
      .mon_src_i(mon_src), .monitor_output_pin_o(mon_pin),
      .monitor_output_pin_oe_o(mon_oe), .fast_pad_switching_o(fast),
      .clock_output_run_o(clk_run));
   pcsm_board u_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe),
      .board_drive_i(board), .pin_level_o(pin_in));

   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   // Outputs trail a register update by one edge
   task automatic settle;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : settle

   task automatic bus(input logic w, input logic [7:0] i,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk_i);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, i, 2'b00};
      do @(posedge mclk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk_i); while (hready !== 1'b1);
      q = hrdata;
      settle();
   endtask : bus

   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, i, 32'h0, q);
      `CHK(q, e)
   endtask : rd

   function automatic logic mexp(int c, logic [5:0] s);
      return c < 4 ? c[0] : s[9 - c];
   endfunction : mexp

   initial begin
      #300000;
      miscompares++;
      conclude();
   end

   initial begin
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      `CHK(clk_run, 1'b1)
      `CHK(hresp, 1'b0)
      rd(8'h44, 32'h0);
      wr(8'h7f, 32'h0);
      rd(8'h7f, {24'h0, VER, SUB});
      rd(8'h50, 32'h0);
      $display("test done: reset and revision");
      wr(8'h44, 32'hFF);
      rd(8'h44, 32'hFF);
      `CHK(pin_oe, 8'hFF)
      `CHK(clk_run, 1'b0)
      @(posedge mclk_i);
      scan_on <= 1'b1;
      settle();
      `CHK(pin_oe, 8'hF0)
      @(posedge mclk_i);
      scan_on <= 1'b0;
      wr(8'h45, 32'hA5);
      `CHK(pin_out, 8'hA5)
      rd(8'h46, 32'hA5);
      wr(8'h44, 32'h0);
      rd(8'h46, 32'h3C);
      $display("test done: pins");
      for (int p = 0; p < 2; p++) begin
         @(posedge mclk_i);
         mon_src <= p ? 6'h12 : 6'h2D;
         for (int c = 0; c < 16; c++) begin
            wr(8'h47, 32'hF0 | c);
            rd(8'h47, 32'h80 | c);
            `CHK(fast, 1'b1)
            `CHK(mon_oe, c inside {[2:9]})
            if (c inside {[2:9]}) `CHK(mon_pin, mexp(c, mon_src))
         end
      end
      $display("test done: monitor");
      conclude();
   end
endmodule : tb
`default_nettype wire

// [verilog/pcsm_pkg.sv]
// Package for the pin configuration and signal monitor block
package pcsm_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_PIN_OUTPUT_ENABLE = 8'h44;
   localparam logic [7:0] IDX_PIN_OUTPUT_VALUE  = 8'h45;
   localparam logic [7:0] IDX_PIN_INPUT_LEVEL   = 8'h46;
   localparam logic [7:0] IDX_MONITOR_SELECT    = 8'h47;
   localparam logic [7:0] IDX_SILICON_REVISION  = 8'h7f;

   // Field positions
   localparam int BIT_SIGNAL_INPUT     = 7;
   localparam int BIT_CLOCK_OUTPUT     = 6;
   localparam int BIT_IFACE_SEL_ONE    = 5;
   localparam int BIT_IFACE_SEL_ZERO   = 4;
   localparam int BIT_FAST_PAD         = 7;
   localparam int NUM_PINS             = 8;
   localparam int NUM_SCAN_PINS        = 4;

   // Reset values and monitor select write mask
   localparam logic [7:0] RST_PIN_ENABLE  = 8'h00;
   localparam logic [7:0] RST_PIN_OUTPUT  = 8'h00;
   localparam logic [7:0] RST_MON_SELECT  = 8'h00;
   localparam logic [7:0] MON_SELECT_MASK = 8'h8f;

   // Monitor source codes
   typedef enum logic [3:0] {
      MON_HIZ_A      = 4'h0,
      MON_HIZ_B      = 4'h1,
      MON_LOW        = 4'h2,
      MON_HIGH       = 4'h3,
      MON_TX_ENV     = 4'h4,
      MON_TX_ACTIVE  = 4'h5,
      MON_SERIAL     = 4'h6,
      MON_RX_ENV     = 4'h7,
      MON_RX_ACTIVE  = 4'h8,
      MON_RX_BITS    = 4'h9
   } pcsm_mon_sel_t;

   // Bus slave phase
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_DATA = 1'b1
   } pcsm_bus_state_t;

   // Internal monitor signals from the transceiver
   typedef struct packed {
      logic tx_envelope;
      logic tx_active;
      logic generic_serial_monitor_signal;
      logic rx_envelope;
      logic rx_active;
      logic rx_bits;
   } pcsm_monitor_t;

   // Whole state of the block
   typedef struct packed {
      pcsm_bus_state_t bus_state;
      logic            wr_pend;
      logic [7:0]      wr_idx;
      logic [31:0]     rdata;
      logic [7:0]      pin_output_enable;
      logic [7:0]      pin_output_value;
      logic [7:0]      pin_input_level;
      logic [7:0]      monitor_output_select;
      logic [7:0]      pin_oe;
      logic [7:0]      pin_out;
      logic            mon_out;
      logic            mon_oe;
      logic            fast_pad;
      logic            clk_out_run;
   } pcsm_state_t;

endpackage : pcsm_pkg

// [verilog/pcsm_top.sv]
// Pin configuration, GPIO and signal monitor block with AHB-Lite registers
//
// Overview of operation
// - Enable bit 7 drives the signal-input pin as general I/O.
// - Enable bit 6 stops clock output and makes that pin general I/O.
// - Enable bits 5 and 4 drive interface-select pins one and zero.
// - Enable bits 3..0 drive scan pins unless boundary scan is strapped on.
// - Output register bits give driven level of each enabled pin.
// - Input register returns sampled level of all eight pins.
// - Monitor register bit 7 selects fast pad switching.
// - Selector 0h/1h float monitor pin, 2h drives low, 3h high.
// - Selector 4h, 5h, 6h show transmit envelope, active, serial monitor.
// - Selector 7h shows receive envelope, valid for 106 kBd type A.
// - Selector 8h shows receive active, 9h received bit stream.
// - Revision register reads version and subversion; writes ignored.
// - Pin-enable register sits at index 44h, fully read/write.
`timescale 1ns/1ps
`default_nettype none

module pcsm_top #(
   // Arbitrary neutral identity values
   parameter logic [3:0] SILICON_VERSION    = 4'h3,
   parameter logic [3:0] SILICON_SUBVERSION = 4'h5,
   parameter int         PIN_COUNT          = 8
) (
   // Clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  resetn_i,
   // AHB-Lite slave
   input  wire logic                  hsel_i,
   input  wire logic [31:0]           haddr_i,
   input  wire logic [1:0]            htrans_i,
   input  wire logic                  hwrite_i,
   input  wire logic [2:0]            hsize_i,
   input  wire logic [31:0]           hwdata_i,
   input  wire logic                  hready_i,
   output logic      [31:0]           hrdata_o,
   output logic                       hreadyout_o,
   output logic                       hresp_o,
   // Multiplexed pins: 7 sig-in, 6 clk-out, 5/4 iface sel, 3..0 scan
   input  wire logic [7:0]            pin_in_i,
   output logic      [7:0]            pin_out_o,
   output logic      [7:0]            pin_oe_o,
   input  wire logic                  boundary_scan_on_i,
   // Monitor sources and monitor pin
   input  wire pcsm_pkg::pcsm_monitor_t mon_src_i,
   output logic                       monitor_output_pin_o,
   output logic                       monitor_output_pin_oe_o,
   // Pad and clock-output control
   output logic                       fast_pad_switching_o,
   output logic                       clock_output_run_o
);

   // Register fields are byte wide, so only eight pins fit
   if (PIN_COUNT != pcsm_pkg::NUM_PINS) begin : g_bad_pin_count
      $error("pcsm_top: only eight pins are supported");
   end

   pcsm_pkg::pcsm_state_t st;
   pcsm_pkg::pcsm_state_t next_st;

   logic                  take;
   logic [7:0]            a_idx;
   logic [7:0]            rd_val;
   logic [7:0]            eff_en;
   logic                  mon_bit;
   logic                  mon_en;
   pcsm_pkg::pcsm_mon_sel_t sel;

   assign take  = hsel_i & hready_i & htrans_i[1];
   assign a_idx = haddr_i[9:2];
   assign sel   = pcsm_pkg::pcsm_mon_sel_t'(st.monitor_output_select[3:0]);

   // Read mux, combinational on the address phase
   always_comb begin
      rd_val = 8'h00;
      case (a_idx)
         pcsm_pkg::IDX_PIN_OUTPUT_ENABLE: rd_val = st.pin_output_enable;
         pcsm_pkg::IDX_PIN_OUTPUT_VALUE:  rd_val = st.pin_output_value;
         pcsm_pkg::IDX_PIN_INPUT_LEVEL:   rd_val = st.pin_input_level;
         pcsm_pkg::IDX_MONITOR_SELECT:    rd_val = st.monitor_output_select;
         pcsm_pkg::IDX_SILICON_REVISION:
            rd_val = {SILICON_VERSION, SILICON_SUBVERSION};
         default:                         rd_val = 8'h00;
      endcase
   end

   // Pin drive enables
   always_comb begin
      eff_en = st.pin_output_enable;
      if (boundary_scan_on_i)
         eff_en[pcsm_pkg::NUM_SCAN_PINS-1:0] = 4'h0;
   end

   // Monitor pin source
   always_comb begin
      mon_bit = 1'b0;
      mon_en  = 1'b1;
      case (sel)
         pcsm_pkg::MON_HIZ_A:     mon_en  = 1'b0;
         pcsm_pkg::MON_HIZ_B:     mon_en  = 1'b0;
         pcsm_pkg::MON_LOW:       mon_bit = 1'b0;
         pcsm_pkg::MON_HIGH:      mon_bit = 1'b1;
         pcsm_pkg::MON_TX_ENV:    mon_bit = mon_src_i.tx_envelope;
         pcsm_pkg::MON_TX_ACTIVE: mon_bit = mon_src_i.tx_active;
         pcsm_pkg::MON_SERIAL:
            mon_bit = mon_src_i.generic_serial_monitor_signal;
         pcsm_pkg::MON_RX_ENV:    mon_bit = mon_src_i.rx_envelope;
         pcsm_pkg::MON_RX_ACTIVE: mon_bit = mon_src_i.rx_active;
         pcsm_pkg::MON_RX_BITS:   mon_bit = mon_src_i.rx_bits;
         default:                 mon_en  = 1'b0;
      endcase
   end

   always_comb begin
      next_st = st;
      // Zero wait states: always ready, always OKAY
      next_st.bus_state = take ? pcsm_pkg::BUS_DATA : pcsm_pkg::BUS_IDLE;
      next_st.wr_pend   = take & hwrite_i;
      if (take) begin
         next_st.wr_idx = a_idx;
         next_st.rdata  = hwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_val};
      end
      // Write lands in the data phase
      if (st.wr_pend) begin
         case (st.wr_idx)
            pcsm_pkg::IDX_PIN_OUTPUT_ENABLE:
               next_st.pin_output_enable = hwdata_i[7:0];
            pcsm_pkg::IDX_PIN_OUTPUT_VALUE:
               next_st.pin_output_value = hwdata_i[7:0];
            // fast pad bit kept, reserved bits dropped
            pcsm_pkg::IDX_MONITOR_SELECT:
               next_st.monitor_output_select =
                  hwdata_i[7:0] & pcsm_pkg::MON_SELECT_MASK;
            default: next_st.pin_input_level = next_st.pin_input_level;
         endcase
      end
      next_st.pin_input_level = pin_in_i;
      next_st.pin_oe  = eff_en;
      next_st.pin_out = st.pin_output_value;
      next_st.mon_out = mon_bit;
      next_st.mon_oe  = mon_en;
      next_st.fast_pad =
         st.monitor_output_select[pcsm_pkg::BIT_FAST_PAD];
      // clock output stops while pin is general I/O
      next_st.clk_out_run =
         ~st.pin_output_enable[pcsm_pkg::BIT_CLOCK_OUTPUT];
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st.bus_state             <= pcsm_pkg::BUS_IDLE;
         st.wr_pend               <= 1'b0;
         st.wr_idx                <= 8'h00;
         st.rdata                 <= 32'h0000_0000;
         st.pin_output_enable     <= pcsm_pkg::RST_PIN_ENABLE;
         st.pin_output_value      <= pcsm_pkg::RST_PIN_OUTPUT;
         st.pin_input_level       <= 8'h00;
         st.monitor_output_select <= pcsm_pkg::RST_MON_SELECT;
         st.pin_oe                <= 8'h00;
         st.pin_out               <= 8'h00;
         st.mon_out               <= 1'b0;
         st.mon_oe                <= 1'b0;
         st.fast_pad              <= 1'b0;
         st.clk_out_run           <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata_o                = st.rdata;
   assign hreadyout_o             = 1'b1;
   assign hresp_o                 = 1'b0;
   assign pin_out_o               = st.pin_out;
   assign pin_oe_o                = st.pin_oe;
   assign monitor_output_pin_o    = st.mon_out;
   assign monitor_output_pin_oe_o = st.mon_oe;
   assign fast_pad_switching_o    = st.fast_pad;
   assign clock_output_run_o      = st.clk_out_run;

endmodule : pcsm_top

`default_nettype wire
